// >>> shared/touch_regs_defs.svh
`ifndef TOUCH_REGS_DEFS_SVH
`define TOUCH_REGS_DEFS_SVH
// ==========================================================
// Register offsets
`define OFS_IRQ_SRC     8'h00
`define OFS_STAT_HIGH   8'h01
`define OFS_STAT_LOW    8'h02
`define OFS_POS_HIGH    8'h03
`define OFS_POS_LOW     8'h04
`define OFS_PIN_LEVELS  8'h07
`define OFS_PARAM_STAT  8'h08
`define OFS_COMP_MODE   8'h09
`define OFS_OUT_CTRL    8'h0a
// ==========================================================
// Field positions
`define IRQ_BURN        6
`define IRQ_PARAM_WR    5
`define IRQ_PIN_EDGE    4
`define IRQ_SLIDER      3
`define IRQ_BUTTON      2
`define IRQ_COMP        1
`define IRQ_MODE        0
`define COMP_BIT        2
`define VALID_BIT       3
// ==========================================================
// Reset values and codes
`define RST_BYTE        8'h00
`define RST_POS         16'h0000
`define MODE_ACTIVE     2'h0
`define MODE_DOZE       2'h1
`define MODE_SLEEP      2'h2
`define MODE_RSVD       2'h3
`define BURN_MANY       3'h4
// ==========================================================
// Host wait after a wake request
`define WAKE_WAIT_MS    300
`endif

// >>> shared/touch_regs_pkg.sv
package touch_regs_pkg;
  // Operating mode codes
  typedef enum logic [1:0] {
    MODE_ACT   = 2'h0,
    MODE_DOZE  = 2'h1,
    MODE_SLEEP = 2'h2,
    MODE_RES   = 2'h3
  } op_mode_t;

  // One cycle of core events raised by the scan engine
  typedef struct packed {
    logic burn_done;
    logic param_write_done;
    logic pin_edge;
    logic slider_event;
    logic button_event;
    logic comp_done;
    logic mode_entered;
  } core_events_t;

  // Touch and slider state from the scan engine
  typedef struct packed {
    logic        move_high;
    logic        move_low;
    logic        slider_touched;
    logic [11:0] buttons;
    logic [15:0] position;
  } touch_state_t;

  // Host byte access after the serial framing
  typedef struct packed {
    logic       start;
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_access_t;
endpackage

// >>> hdl/touch_host_status_control_regs.sv
`include "touch_regs_defs.svh"
module touch_host_status_control_regs #(
  parameter int NPINS = 8                     // General purpose pins
) (
  input  wire logic                        clk,          // 20 MHz clock
  input  wire logic                        rstn,         // Async reset
  input  wire touch_regs_pkg::host_access_t host_acc,    // Host byte access
  output logic [7:0]                       host_rdata,   // Read byte
  output logic                             host_irq_n,   // Interrupt, low
  input  wire logic                        phase_tick,   // Processing phase
  input  wire touch_regs_pkg::core_events_t core_evt,    // Core events
  input  wire touch_regs_pkg::touch_state_t touch_in,    // Touch state
  input  wire logic [NPINS-1:0]            input_pin,    // Pin levels
  input  wire logic [NPINS-1:0]            pin_is_input, // Pin input mode
  input  wire logic [NPINS-1:0]            pin_is_output,// Pin output mode
  input  wire logic                        autolight_on, // Auto lighting
  input  wire logic [NPINS-1:0]            output_powerup_state, // Init
  input  wire logic                        burned_contents_valid, // NVM ok
  input  wire logic [2:0]                  burn_counter, // Burn count
  input  wire logic                        comp_busy,    // Comp running
  input  wire touch_regs_pkg::op_mode_t    cur_mode,     // Mode in effect
  output logic                             comp_start,   // Comp trigger
  output touch_regs_pkg::op_mode_t         mode_req,     // Requested mode
  output logic [NPINS-1:0]                 output_pin,   // On/off select
  output logic                             use_factory   // Defaults used
);

  // ==========================================================
  // Address pointer
  logic [7:0] addr_ff;
  logic [7:0] nxt_addr;
  wire        byte_xfer = host_acc.wr | host_acc.rd;
  wire [7:0]  cur_addr  = host_acc.start ? host_acc.addr : addr_ff;

  // Pointer loads on start, steps after every data byte
  assign nxt_addr = byte_xfer ? cur_addr + 8'h01 : cur_addr;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) addr_ff <= `RST_BYTE;
    else       addr_ff <= nxt_addr;
  end

  wire wr_ctrl = host_acc.wr && (cur_addr == `OFS_COMP_MODE);
  wire wr_out  = host_acc.wr && (cur_addr == `OFS_OUT_CTRL);
  wire rd_irq  = host_acc.rd && (cur_addr == `OFS_IRQ_SRC);

  // ==========================================================
  // Interrupt source flags
  logic [6:0] irq_ff;
  logic [6:0] pend_ff;
  logic [6:0] nxt_irq;
  logic [6:0] nxt_pend;
  wire  [6:0] evt_vec = core_evt;

  // Events gather until the phase tick, then post to flags
  assign nxt_pend = phase_tick ? 7'h00 : (pend_ff | evt_vec);
  wire  [6:0] post = phase_tick ? (pend_ff | evt_vec) : 7'h00;
  // Set wins over a clearing read in the same cycle
  assign nxt_irq = (rd_irq ? 7'h00 : irq_ff) | post;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_ff  <= 7'h00;
      pend_ff <= 7'h00;
    end else begin
      irq_ff  <= nxt_irq;
      pend_ff <= nxt_pend;
    end
  end

  // Pin registered from flag next state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) host_irq_n <= 1'b1;
    else       host_irq_n <= ~(|nxt_irq);
  end

  // ==========================================================
  // Control registers
  logic       comp_req_ff;
  logic [1:0] mode_ff;
  logic [NPINS-1:0] outc_ff;
  logic       init_ff;
  wire  [1:0] wr_mode = host_acc.wdata[1:0];

  // Host writes staged; upper bits ignored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      comp_req_ff <= 1'b0;
      mode_ff     <= `MODE_ACTIVE;
      init_ff     <= 1'b1;
    end else begin
      init_ff <= 1'b0;
      if (wr_ctrl && host_acc.wdata[`COMP_BIT])
        comp_req_ff <= 1'b1;
      else if (phase_tick)
        comp_req_ff <= 1'b0;
      if (wr_ctrl && wr_mode != `MODE_RSVD)
        mode_ff <= wr_mode;
    end
  end

  // Output control takes power-up state after reset release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)        outc_ff <= '0;
    else if (init_ff) outc_ff <= output_powerup_state;
    else if (wr_out)  outc_ff <= host_acc.wdata[NPINS-1:0];
  end

  // Applied mode and pin values change only on a processing phase; comp_start pulses for one cycle after it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      comp_start <= 1'b0;
      mode_req   <= touch_regs_pkg::MODE_ACT;
      output_pin <= '0;
    end else begin
      comp_start <= phase_tick & comp_req_ff;
      if (phase_tick) begin
        mode_req <= touch_regs_pkg::op_mode_t'(mode_ff);
        output_pin <= autolight_on ? output_pin
                    : (output_pin & ~pin_is_output)
                    | (outc_ff & pin_is_output);
      end
    end
  end

  // ==========================================================
  // Status views
  logic [7:0] stat_high;
  logic [7:0] stat_low;
  logic [7:0] pin_lv;
  logic [7:0] pstat;
  logic [7:0] cmode;
  logic [15:0] pos_ff;

  // Position follows while touched, holds after release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)                       pos_ff <= `RST_POS;
    else if (touch_in.slider_touched) pos_ff <= touch_in.position;
  end

  // Move bits only meaningful while touched
  assign stat_high = {1'b0,
                      touch_in.move_high & touch_in.slider_touched,
                      touch_in.move_low  & touch_in.slider_touched,
                      touch_in.slider_touched,
                      touch_in.buttons[11:8]};
  assign stat_low  = touch_in.buttons[7:0];

  // Non-input pins read as zero
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      if (gi < NPINS) begin : g_on
        assign pin_lv[gi] = input_pin[gi] & pin_is_input[gi];
      end else begin : g_off
        assign pin_lv[gi] = 1'b0;
      end
    end
  endgenerate

  // Factory defaults at count 0, counts of 4 or more, or invalid contents
  wire bvalid = burned_contents_valid && burn_counter != 3'h0
                && burn_counter < `BURN_MANY;
  wire [2:0] bcnt = (burn_counter > `BURN_MANY) ? `BURN_MANY
                                               : burn_counter;
  assign pstat = {4'h0, bvalid, bcnt};
  assign cmode = {5'h00, comp_busy | comp_req_ff,
                  cur_mode};

  wire [7:0] rd_mux =
    (cur_addr == `OFS_IRQ_SRC)    ? {1'b0, irq_ff} :
    (cur_addr == `OFS_STAT_HIGH)  ? stat_high :
    (cur_addr == `OFS_STAT_LOW)   ? stat_low :
    (cur_addr == `OFS_POS_HIGH)   ? pos_ff[15:8] :
    (cur_addr == `OFS_POS_LOW)    ? pos_ff[7:0] :
    (cur_addr == `OFS_PIN_LEVELS) ? pin_lv :
    (cur_addr == `OFS_PARAM_STAT) ? pstat :
    (cur_addr == `OFS_COMP_MODE)  ? cmode :
    (cur_addr == `OFS_OUT_CTRL)   ? 8'(outc_ff) :
                                    8'h00;

  // Read data and factory flag registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      host_rdata  <= 8'h00;
      use_factory <= 1'b1;
    end else begin
      if (host_acc.rd) host_rdata <= rd_mux;
      use_factory <= ~bvalid;
    end
  end

  // ==========================================================
  // Checks

  // Clearing read of the source register with no tick
  sequence s_clear_read;
    rd_irq && !phase_tick;
  endsequence

  // Slider event off the tick, then four quiet cycles
  sequence s_slider_wait;
    (core_evt.slider_event && !phase_tick) ##1 !phase_tick [*4];
  endsequence

  // Host write of the reserved mode code
  sequence s_rsvd_mode_wr;
    wr_ctrl && (wr_mode == `MODE_RSVD);
  endsequence

  AST_IRQ_PIN: assert property (
    @(posedge clk) disable iff (!rstn)
    (|irq_ff) |-> !host_irq_n)
    else $error("irq pin high with flag set");

  AST_IRQ_IDLE: assert property (
    @(posedge clk) disable iff (!rstn)
    (irq_ff == 7'h00) |-> host_irq_n)
    else $error("irq pin low with no flag");

  AST_RD_CLEAR: assert property (
    @(posedge clk) disable iff (!rstn)
    s_clear_read |=> (irq_ff == 7'h00 && host_irq_n))
    else $error("read did not clear flags");

  AST_RSVD_IRQ: assert property (
    @(posedge clk) disable iff (!rstn)
    s_clear_read |=> (host_rdata[7] == 1'b0))
    else $error("reserved flag bit read as one");

  AST_POST: assert property (
    @(posedge clk) disable iff (!rstn)
    (phase_tick && core_evt.burn_done) |=> irq_ff[`IRQ_BURN])
    else $error("burn flag not set");

  AST_SET_WINS: assert property (
    @(posedge clk) disable iff (!rstn)
    (rd_irq && phase_tick && core_evt.comp_done) |=> irq_ff[`IRQ_COMP])
    else $error("clearing read beat a new flag");

  AST_HOLD: assert property (
    @(posedge clk) disable iff (!rstn)
    (core_evt.slider_event && !phase_tick) |=> pend_ff[`IRQ_SLIDER])
    else $error("slider event lost");

  AST_SLD_WAIT: assert property (
    @(posedge clk) disable iff (!rstn)
    s_slider_wait |-> pend_ff[`IRQ_SLIDER])
    else $error("slider event dropped while waiting");

  // Every pending flag posts at the tick
  for (gi = 0; gi < 7; gi++) begin : g_post_chk
    AST_FLAG_POST: assert property (
      @(posedge clk) disable iff (!rstn)
      (phase_tick && pend_ff[gi]) |=> irq_ff[gi])
      else $error("pending flag not posted");
  end

  AST_NO_SET: assert property (
    @(posedge clk) disable iff (!rstn)
    !phase_tick |=> (irq_ff & ~$past(irq_ff)) == 7'h00)
    else $error("flag set off phase");

  AST_POS: assert property (
    @(posedge clk) disable iff (!rstn)
    !touch_in.slider_touched |=> $stable(pos_ff))
    else $error("position changed after release");

  AST_MOVE: assert property (
    @(posedge clk) disable iff (!rstn)
    !touch_in.slider_touched |-> (stat_high[6:5] == 2'h0))
    else $error("move bits shown while released");

  AST_PINS: assert property (
    @(posedge clk) disable iff (!rstn)
    (pin_lv[NPINS-1:0] & ~pin_is_input) == '0)
    else $error("non-input pin level shown");

  AST_ADDR: assert property (
    @(posedge clk) disable iff (!rstn)
    (byte_xfer && !host_acc.start) |=> addr_ff == $past(addr_ff) + 8'h01)
    else $error("address did not step");

  AST_COMP: assert property (
    @(posedge clk) disable iff (!rstn)
    (wr_ctrl && host_acc.wdata[`COMP_BIT]) |=> comp_req_ff)
    else $error("compensation request lost");

  AST_COMP_BIT: assert property (
    @(posedge clk) disable iff (!rstn)
    comp_busy |-> cmode[`COMP_BIT])
    else $error("running compensation not shown");

  AST_MODE: assert property (
    @(posedge clk) disable iff (!rstn)
    !phase_tick |=> $stable(mode_req))
    else $error("mode applied off phase");

  AST_MODE_RSVD: assert property (
    @(posedge clk) disable iff (!rstn)
    s_rsvd_mode_wr |=> $stable(mode_ff))
    else $error("reserved mode code taken");

  AST_START: assert property (
    @(posedge clk) disable iff (!rstn)
    comp_start |-> $past(phase_tick))
    else $error("compensation started off phase");

  AST_OUT_HOLD: assert property (
    @(posedge clk) disable iff (!rstn)
    !phase_tick |=> $stable(output_pin))
    else $error("output pins changed off phase");

  AST_CNT: assert property (
    @(posedge clk) disable iff (!rstn)
    burn_counter >= `BURN_MANY |-> pstat[3:0] == 4'h4)
    else $error("burn count not saturated");

  AST_FACTORY: assert property (
    @(posedge clk) disable iff (!rstn)
    (burn_counter == 3'h0) |=> use_factory)
    else $error("defaults not used with no burn");

endmodule

// >>> sim/host_master.sv
// ==========================================================
// Host side: byte accesses as left after the serial framing
module host_master (
  input  wire logic                    clk,   // Clock
  output touch_regs_pkg::host_access_t acc,   // Byte access
  input  wire logic [7:0]              rdata  // Read byte
);
  timeunit 1ns;
  timeprecision 1ns;

  initial acc = '0;

  // Burst read, start on the first byte only; the pointer does the rest
  task automatic rd(input logic [7:0] a, input int n,
                    output logic [7:0] q [8]);
    for (int i = 0; i <= n; i++) begin
      @(posedge clk);
      #1;
      if (i > 0) q[i-1] = rdata;
      acc = '{i == 0, 1'b0, i < n, a, 8'h00};
    end
  endtask

  // Single byte write; callers keep unused control bits at zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    acc = '{1'b1, 1'b1, 1'b0, a, d};
    @(posedge clk);
    #1;
    acc = '0;
  endtask
endmodule

// >>> sim/tb.sv
// ==========================================================
// Bench for the host status and control registers
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, tick = 0, alight = 0, valid = 0, busy = 0;
  logic [7:0] pin = 0, isin = 0, isout = 8'hff, pwr = 8'h5a;
  logic [2:0] cnt = 0;
  touch_regs_pkg::core_events_t evt = '0;
  touch_regs_pkg::touch_state_t tin = '0;
  touch_regs_pkg::op_mode_t cur = touch_regs_pkg::MODE_ACT;
  touch_regs_pkg::op_mode_t mreq;
  touch_regs_pkg::host_access_t acc;
  logic [7:0] rdata, opin, starts = 0;
  logic irq_n, cstart, ufac;
  logic [7:0] q [8];
  int miscompares = 0, num_checks = 0;

  always #25 clk = ~clk;
  // Mode engine follows the request; count compensation triggers
  always @(posedge clk) cur <= mreq;
  always @(posedge clk) if (cstart === 1'b1) starts <= starts + 8'h01;

  touch_host_status_control_regs #(.NPINS(8)) dut_u (
    .clk(clk), .rstn(rstn), .host_acc(acc), .host_rdata(rdata),
    .host_irq_n(irq_n), .phase_tick(tick), .core_evt(evt),
    .touch_in(tin), .input_pin(pin), .pin_is_input(isin),
    .pin_is_output(isout), .autolight_on(alight),
    .output_powerup_state(pwr), .burned_contents_valid(valid),
    .burn_counter(cnt), .comp_busy(busy), .cur_mode(cur),
    .comp_start(cstart), .mode_req(mreq), .output_pin(opin),
    .use_factory(ufac));
  host_master host_u (.clk(clk), .acc(acc), .rdata(rdata));

  // ==========================================================
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tk;
    @(posedge clk);
    #1 tick = 1;
    @(posedge clk);
    #1 tick = 0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // ==========================================================
  // Scenarios
  // Wake report: the host waits for the pin before any read
  task automatic wake;
    @(posedge clk);
    #1 evt = 7'h01;
    @(posedge clk);
    #1 evt = '0;
    tk();
    for (int k = 0; k < 20 && irq_n !== 1'b0; k++) @(posedge clk);
    #1;
    chk({7'h00, irq_n}, 8'h00);
    host_u.rd(8'h00, 1, q);
    chk(q[0], 8'h01);
  endtask

  task automatic t_reset;
    chk({7'h00, irq_n}, 8'h01);
    chk(opin, 8'h00);
    chk({7'h00, ufac}, 8'h01);
    host_u.rd(8'h00, 5, q);
    chk(q[0], 8'h00);
    chk(q[3], 8'h00);
    chk(q[4], 8'h00);
    host_u.rd(8'h0a, 1, q);
    chk(q[0], pwr);
    $display("reset test done");
  endtask

  task automatic t_irq;
    for (int b = 0; b < 8; b++) begin
      @(posedge clk);
      #1 evt = (b == 7) ? 7'h7f : 7'(1 << b);
      @(posedge clk);
      #1 evt = '0;
      repeat (3) @(posedge clk);
      #1;
      chk({7'h00, irq_n}, 8'h01);
      tk();
      chk({7'h00, irq_n}, 8'h00);
      host_u.rd(8'h00, 1, q);
      chk(q[0], (b == 7) ? 8'h7f : 8'(1 << b));
      @(posedge clk);
      #1;
      chk({7'h00, irq_n}, 8'h01);
      host_u.rd(8'h00, 1, q);
      chk(q[0], 8'h00);
    end
    // Events on the tick post at once and beat a clearing read
    fork
      host_u.rd(8'h00, 1, q);
      begin
        @(posedge clk);
        #1 evt = 7'h42;
        tick = 1;
        @(posedge clk);
        #1 evt = '0;
        tick = 0;
      end
    join
    chk(q[0], 8'h00);
    @(posedge clk);
    #1;
    chk({7'h00, irq_n}, 8'h00);
    host_u.rd(8'h00, 1, q);
    chk(q[0], 8'h42);
    $display("interrupt test done");
  endtask

  task automatic t_status;
    tin = '{1'b1, 1'b0, 1'b1, 12'ha5c, 16'hbe37};
    tk();
    host_u.rd(8'h01, 4, q);
    chk(q[0], 8'h5a);
    chk(q[1], 8'h5c);
    chk(q[2], 8'hbe);
    chk(q[3], 8'h37);
    tin = '{1'b1, 1'b0, 1'b0, 12'ha5c, 16'h1234};
    tk();
    host_u.rd(8'h01, 4, q);
    chk(q[0], 8'h0a);
    chk(q[2], 8'hbe);
    chk(q[3], 8'h37);
    $display("status test done");
  endtask

  task automatic t_pins;
    logic [3:0] tab [4];
    logic [3:0] ex [4];
    tab = '{4'hb, 4'hc, 4'h2, 4'h8};
    ex = '{4'hb, 4'h4, 4'h2, 4'h0};
    pin = 8'hf0;
    isin = 8'h3c;
    tk();
    host_u.rd(8'h07, 1, q);
    chk(q[0], 8'h30);
    for (int i = 0; i < 4; i++) begin
      {valid, cnt} = tab[i];
      tk();
      host_u.rd(8'h08, 1, q);
      chk(q[0] & 8'h0f, {4'h0, ex[i]});
      chk({7'h00, ufac}, {7'h00, ~ex[i][3]});
    end
    $display("pin and memory status test done");
  endtask

  task automatic t_ctrl;
    logic [1:0] e, m;
    host_u.wr(8'h0a, 8'h96);
    chk(opin, pwr);
    tk();
    chk(opin, 8'h96);
    // Auto lighting holds the pins; non-output bits stay put
    alight = 1;
    isout = 8'h0f;
    host_u.wr(8'h0a, 8'h00);
    tk();
    chk(opin, 8'h96);
    alight = 0;
    tk();
    chk(opin, 8'h90);
    e = 2'h0;
    for (int i = 0; i < 4; i++) begin
      m = 2'(i + 1);
      host_u.wr(8'h09, {6'h00, m});
      chk({6'h00, mreq}, {6'h00, e});
      if (m != 2'h3) e = m;
      tk();
      chk({6'h00, mreq}, {6'h00, e});
      if (m == 2'h0 || m == 2'h1) wake();
      host_u.rd(8'h09, 1, q);
      chk(q[0], {6'h00, e});
    end
    host_u.wr(8'h09, 8'h04);
    chk(starts, 8'h00);
    busy = 1;
    tk();
    chk(starts, 8'h01);
    host_u.rd(8'h09, 1, q);
    chk(q[0], 8'h04);
    busy = 0;
    tk();
    host_u.rd(8'h09, 1, q);
    chk(q[0], 8'h00);
    $display("control test done");
  endtask

  // ==========================================================
  // Verdict, main sequence and watchdog
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #1 rstn = 1;
    repeat (2) @(posedge clk);
    #1;
    t_reset();
    t_irq();
    t_status();
    t_pins();
    t_ctrl();
    summarize();
  end

  initial begin
    #200us;
    miscompares++;
    summarize();
  end
endmodule
